// ==== src/rtc_timer_pkg.sv ====
// Constants shared by the real-time clock timer block
package rtc_timer_pkg;
    // ****************************************************************
    // Register indices and byte addresses
    // ****************************************************************
    localparam logic [11:0] IDX_RTC_COUNT = 12'h100; // Count register index
    localparam logic [11:0] IDX_RTC_PERIOD = 12'h102; // Period register index
    localparam logic [11:0] IDX_RTC_CONTROL = 12'h104; // Control register index
    localparam logic [11:0] IDX_INT_FLAG = 12'h106; // Interrupt flag status index
    localparam logic [11:0] IDX_INT_ENABLE = 12'h108; // Interrupt enable index
    localparam logic [11:0] IDX_OSC_CONTROL = 12'h10a; // Oscillator control index
    localparam int ADDR_W = 14; // Byte address width used for decode
    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BIT_TIMER_ON = 15; // Timer on
    localparam int BIT_STOP_IN_IDLE = 13; // Stop in idle
    localparam int BIT_GATE = 6; // Gated accumulate enable
    localparam int BIT_PRESC_HI = 5; // Prescale select msb
    localparam int BIT_PRESC_LO = 4; // Prescale select lsb
    localparam int BIT_SYNC = 2; // External sync select
    localparam int BIT_CLK_SRC = 1; // Clock source select
    localparam int BIT_PERIOD_FLAG = 0; // Period flag in flag/enable regs
    localparam int BIT_LPOSC = 1; // Low power osc enable
    // ****************************************************************
    // Reset values and masks
    // ****************************************************************
    localparam logic [15:0] RST_PERIOD = 16'hffff; // Period reset value
    localparam logic [15:0] RST_CONTROL = 16'h0000; // Control reset value
    localparam logic [15:0] RST_COUNT = 16'h0000; // Count reset value
    localparam logic [15:0] CTRL_WR_MASK = 16'ha076; // Implemented control bits
    // ****************************************************************
    // Prescaler terminal counts (ratio minus one)
    // ****************************************************************
    localparam logic [7:0] PRESC_LIM_1 = 8'h00; // 1:1
    localparam logic [7:0] PRESC_LIM_8 = 8'h07; // 1:8
    localparam logic [7:0] PRESC_LIM_64 = 8'h3f; // 1:64
    localparam logic [7:0] PRESC_LIM_256 = 8'hff; // 1:256
endpackage

// ==== src/rtc_timer.sv ====
// Real-time clock timer with APB register slave
//
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
// Notes on behaviour
// - Time-of-day counter clocked from 32 kHz oscillator
// - Mode chosen by control register bits and CPU idle
// - On, external source, ungated: count rising edges
// - Count equal period wraps to zero next
// - Low-power enable gives carry-out wake-up event
// - Keeps counting during CPU sleep
// - Match sets period flag; request if enabled
// - Request forwarded only when enable bit set
// - Prescaler 1, 8, 64 or 256 selectable
// - Prescaler cleared by count write, off, reset
// - Control write leaves count untouched
// - Control bit layout 15,13,6,5:4,2,1
module rtc_timer
    import rtc_timer_pkg::*;
(
    input wire logic clk, // 125 MHz system clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic oscIn, // 32 kHz oscillator, asynchronous
    input wire logic cpuIdle, // CPU in idle mode
    input wire logic cpuSleep, // CPU in sleep mode
    output logic irq, // Period interrupt request
    output logic wakeEvent // Carry-out wake-up pulse
);
    // ****************************************************************
    // Register bus decode
    // ****************************************************************
    logic [31:0] prdataReg; // Read data captured in setup phase
    logic [15:0] countReg; // Count
    logic [15:0] periodReg; // Period
    logic [15:0] ctrlReg; // Control
    logic flagReg; // Period interrupt flag
    logic intEnReg; // Period interrupt enable
    logic lposcReg; // Low power oscillator enable
    logic [7:0] prescCnt; // Prescaler counter
    logic oscS1, oscS2, oscS3; // Oscillator synchroniser and edge history
    wire setupPh = psel && !penable; // Setup phase
    wire accessPh = psel && penable; // Access phase, always ready
    wire wrAcc = accessPh && pwrite; // Write takes effect here
    wire aligned = (paddr[1:0] == 2'b00); // Word-aligned access only
    wire [11:0] idx = paddr[ADDR_W-1:2]; // Register index
    wire hitCount = aligned && idx == IDX_RTC_COUNT; // Count selected
    wire hitPeriod = aligned && idx == IDX_RTC_PERIOD; // Period selected
    wire hitCtrl = aligned && idx == IDX_RTC_CONTROL; // Control selected
    wire hitFlag = aligned && idx == IDX_INT_FLAG; // Flag status selected
    wire hitEn = aligned && idx == IDX_INT_ENABLE; // Enable selected
    wire hitOsc = aligned && idx == IDX_OSC_CONTROL; // Osc control selected
    wire mapped = hitCount || hitPeriod || hitCtrl || hitFlag || hitEn || hitOsc; // Any register
    wire countWr = wrAcc && hitCount; // Count write
    wire periodWr = wrAcc && hitPeriod; // Period write
    wire ctrlWr = wrAcc && hitCtrl; // Control write
    wire flagWr = wrAcc && hitFlag; // Flag write
    wire enWr = wrAcc && hitEn; // Enable write
    wire oscWr = wrAcc && hitOsc; // Osc control write
    // Read mux; narrow registers sit low, upper bits zero
    wire [31:0] rdMux = hitCount ? {16'h0000, countReg} :
                        hitPeriod ? {16'h0000, periodReg} :
                        hitCtrl ? {16'h0000, ctrlReg} :
                        hitFlag ? {31'h00000000, flagReg} :
                        hitEn ? {31'h00000000, intEnReg} :
                        hitOsc ? {30'h00000000, lposcReg, 1'b0} : 32'h00000000;
    assign pready = 1'b1; // Zero wait states
    assign pslverr = accessPh && !mapped; // Unmapped or misaligned
    assign prdata = prdataReg;
    // Capture read data in the setup cycle so it comes from a flop
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdataReg <= 32'h00000000;
        end else if (setupPh) begin
            prdataReg <= rdMux;
        end
    end
    // ****************************************************************
    // Control fields
    // ****************************************************************
    wire timerOn = ctrlReg[BIT_TIMER_ON];
    wire stopInIdle = ctrlReg[BIT_STOP_IN_IDLE];
    wire gateEn = ctrlReg[BIT_GATE];
    wire [1:0] prescSel = ctrlReg[BIT_PRESC_HI:BIT_PRESC_LO];
    wire clkSrcSel = ctrlReg[BIT_CLK_SRC]; // External clock chosen
    // Run decided by control bits and CPU idle; sleep never stops it
    wire runEn = timerOn && clkSrcSel && !gateEn && !(cpuIdle && stopInIdle);
    // Control register: only implemented bits are writable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrlReg <= RST_CONTROL;
        end else if (ctrlWr) begin
            ctrlReg <= pwdata[15:0] & CTRL_WR_MASK;
        end
    end
    // ****************************************************************
    // Oscillator synchroniser and edge detect
    // ****************************************************************
    // Two flops before any logic; third flop only for edge history
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            oscS1 <= 1'b0;
            oscS2 <= 1'b0;
            oscS3 <= 1'b0;
        end else begin
            oscS1 <= oscIn;
            oscS2 <= oscS1;
            oscS3 <= oscS2;
        end
    end
    wire oscRise = oscS2 && !oscS3; // Rising edge of the 32 kHz clock
    // ****************************************************************
    // Prescaler
    // ****************************************************************
    // Terminal count from the two-bit select
    wire [7:0] prescLim = (prescSel == 2'b00) ? PRESC_LIM_1 :
                          (prescSel == 2'b01) ? PRESC_LIM_8 :
                          (prescSel == 2'b10) ? PRESC_LIM_64 : PRESC_LIM_256;
    wire prescEdge = runEn && oscRise; // Prescaler clock
    wire tick = prescEdge && (prescCnt == prescLim); // Counter increment
    wire tonClear = ctrlWr && !pwdata[BIT_TIMER_ON]; // Timer being switched off
    // Prescaler frozen while off, cleared on count write or switch-off
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prescCnt <= 8'h00;
        end else if (countWr || tonClear) begin
            prescCnt <= 8'h00;
        end else if (tick) begin
            prescCnt <= 8'h00;
        end else if (prescEdge) begin
            prescCnt <= prescCnt + 8'h01;
        end
    end
    // ****************************************************************
    // Counter and period
    // ****************************************************************
    wire atPeriod = (countReg == periodReg); // Match
    wire matchEv = tick && atPeriod; // One per wrap
    // A software write beats a tick in the same cycle; all in one domain
    // so the written value can never tear against an increment
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            countReg <= RST_COUNT;
        end else if (countWr) begin
            countReg <= pwdata[15:0];
        end else if (matchEv) begin
            countReg <= 16'h0000;
        end else if (tick) begin
            countReg <= countReg + 16'h0001;
        end
    end
    // Period register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            periodReg <= RST_PERIOD;
        end else if (periodWr) begin
            periodReg <= pwdata[15:0];
        end
    end
    // ****************************************************************
    // Flag, enable, oscillator control, wake-up
    // ****************************************************************
    // Set wins over a software clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flagReg <= 1'b0;
            intEnReg <= 1'b0;
            lposcReg <= 1'b0;
        end else begin
            if (matchEv) begin
                flagReg <= 1'b1;
            end else if (flagWr) begin
                flagReg <= pwdata[BIT_PERIOD_FLAG];
            end
            if (enWr) begin
                intEnReg <= pwdata[BIT_PERIOD_FLAG];
            end
            if (oscWr) begin
                lposcReg <= pwdata[BIT_LPOSC];
            end
        end
    end
    assign irq = flagReg && intEnReg;
    // Carry-out pulse only when the low power oscillator is enabled
    assign wakeEvent = matchEv && lposcReg;
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_WRAP: assert property (matchEv && !countWr |=> countReg == 16'h0000)
        else $error("count did not wrap at period");
    AST_INC: assert property (tick && !atPeriod && !countWr |=> countReg == $past(countReg) + 16'h0001)
        else $error("count did not increment on tick");
    AST_HOLD: assert property (!runEn && !countWr |=> $stable(countReg))
        else $error("count moved while not running");
    AST_FLAG: assert property (matchEv |=> flagReg ##1 (flagReg || $past(flagWr)))
        else $error("flag not set by match");
    AST_IRQ: assert property (flagReg && !intEnReg |-> !irq)
        else $error("request without enable");
    AST_PRESC: assert property (countWr |=> prescCnt == 8'h00)
        else $error("prescaler not cleared by count write");
    AST_CTRL: assert property (ctrlWr && !tick |=> countReg == $past(countReg))
        else $error("control write changed count");
    AST_WAKE: assert property (!lposcReg |-> !wakeEvent)
        else $error("wake-up without low power enable");
    // The first seven prescaler edges at 1:8 must leave the count alone
    AST_DIV8: assert property (prescEdge && prescSel == 2'b01 && prescCnt < 8'h07 && !countWr |=> $stable(countReg))
        else $error("divide by eight wrong");
    // A detected rise was high one edge back and low two edges back
    AST_EDGE: assert property (oscRise |-> $past(oscS1) && !$past(oscS1, 2))
        else $error("edge not from synchronised oscillator");
    // Sleep has no say in counting; a tick still advances the count
    AST_SLEEP: assert property (cpuSleep && tick && !atPeriod && !countWr |=> countReg == $past(countReg) + 16'h0001)
        else $error("count stalled in sleep");
    COV_WRAP: cover property (matchEv);
    COV_IRQ: cover property (irq && matchEv ##1 irq);
    COV_WAKE: cover property (wakeEvent);
    COV_CLEAR: cover property (flagWr && !pwdata[0] ##1 !flagReg);
endmodule

// ==== tb/osc_model.sv ====
// Behavioural model of the external low-power crystal oscillator
`timescale 1ns/10ps
module osc_model #(
    parameter int HALF_NS = 45 // Half period, scaled down from 32 kHz
) (
    input wire logic run, // Oscillator active while high
    output logic oscIn // Oscillator output to the timer
);
    // ********
    // Oscillation
    // ********
    // Stands low between bursts; a whole period always completes
    initial oscIn = 1'b0;
    // Burst starts 1 ns off the clk edge and the 90 ns period keeps rises
    // on odd nanoseconds, so no rise ever races a sampling edge
    always begin
        wait (run);
        #1;
        while (run) begin
            oscIn = 1'b1; // Rising edge counted by the timer
            #HALF_NS;
            oscIn = 1'b0; // High and low each outlast three clk cycles
            #HALF_NS;
        end
    end
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the real-time clock timer
`timescale 1ns/10ps
module tb;
    import rtc_timer_pkg::*;
    // ********
    // Signals
    // ********
    logic clk = 1'b0; // System clock
    logic rst_n = 1'b0; // Reset, active low
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
    logic [ADDR_W-1:0] paddr = '0; // APB address
    logic [31:0] pwdata = '0, prdata, rd; // APB data and last read
    logic pready, pslverr, se, irq, wakeEvent, oscIn; // Design outputs
    logic cpuIdle = 1'b0, cpuSleep = 1'b0, run = 1'b0; // CPU state, oscillator run
    int errTotal = 0, samplesChecked = 0, cycles = 0, wakes = 0; // Counters
    logic [31:0] blk [3] = '{32'h8042, 32'h0002, 32'ha002}; // Settings that must not count
    int ratio [4] = '{1, 8, 64, 256}; // Prescale ratios by select code
    always #4 clk = ~clk; // 125 MHz
    rtc_timer i_rtc_timer (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .oscIn(oscIn), .cpuIdle(cpuIdle), .cpuSleep(cpuSleep), .irq(irq), .wakeEvent(wakeEvent));
    osc_model i_osc_model (.run(run), .oscIn(oscIn));
    // ********
    // Tasks
    // ********
    // One APB transfer; caller stands just after a rising edge
    task automatic apb(input logic isWr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= isWr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No fixed latency assumed; the cycle ceiling ends a hang
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            errTotal++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic checkBit(input logic got, input logic exp);
        checkWord({31'h0, got}, {31'h0, exp});
    endtask
    // Registers sit two words apart: byte address is four times the index
    task automatic wr(input logic [11:0] idx, input logic [31:0] d);
        apb(1'b1, {idx, 2'b00}, d);
    endtask
    task automatic rdChk(input logic [11:0] idx, input logic [31:0] exp);
        apb(1'b0, {idx, 2'b00}, 32'h0);
        checkWord(rd, exp);
    endtask
    // Exactly n oscillator rises, then room for the synchroniser
    task automatic ticks(input int n);
        run <= 1'b1;
        repeat (n) @(posedge oscIn);
        @(posedge clk);
        run <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
    task automatic endTest(input string name);
        $display("Test %s done", name);
    endtask
    task automatic results();
        $display("Checks %0d, mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ********
    // Monitors and timeout
    // ********
    always @(posedge clk) begin
        cycles++;
        if (wakeEvent === 1'b1) begin
            wakes++; // One-cycle pulses
        end
        if (cycles == 50000) begin
            errTotal++;
            results();
        end
    end
    // ********
    // Test sequence
    // ********
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdChk(IDX_RTC_COUNT, 32'h0);
        rdChk(IDX_RTC_PERIOD, 32'hffff);
        rdChk(IDX_RTC_CONTROL, 32'h0);
        apb(1'b0, 14'h0430, 32'h0);
        checkBit(se, 1'b1);
        endTest("reset");
        wr(IDX_RTC_COUNT, 32'h1234);
        wr(IDX_RTC_CONTROL, 32'hffff);
        rdChk(IDX_RTC_CONTROL, 32'ha076);
        rdChk(IDX_RTC_COUNT, 32'h1234);
        // Gate on, timer off, idle with stop set: count must hold
        cpuIdle <= 1'b1;
        foreach (blk[i]) begin
            wr(IDX_RTC_CONTROL, blk[i]);
            ticks(3);
            rdChk(IDX_RTC_COUNT, 32'h1234);
        end
        cpuIdle <= 1'b0;
        endTest("hold");
        // Sleep does not stop counting; wrap at period 3
        cpuSleep <= 1'b1;
        cpuIdle <= 1'b1; // Idle with stop clear keeps counting
        wr(IDX_RTC_PERIOD, 32'h3);
        wr(IDX_INT_ENABLE, 32'h1);
        wr(IDX_OSC_CONTROL, 32'h2);
        wr(IDX_RTC_CONTROL, 32'h8002);
        wr(IDX_RTC_COUNT, 32'h0);
        wakes = 0;
        ticks(6);
        rdChk(IDX_RTC_COUNT, 32'h2);
        checkWord(32'(wakes), 32'h1);
        rdChk(IDX_INT_FLAG, 32'h1);
        checkBit(irq, 1'b1);
        wr(IDX_INT_FLAG, 32'h0);
        checkBit(irq, 1'b0);
        wr(IDX_INT_ENABLE, 32'h0);
        ticks(2);
        rdChk(IDX_RTC_COUNT, 32'h0);
        rdChk(IDX_INT_FLAG, 32'h1);
        checkBit(irq, 1'b0);
        wr(IDX_OSC_CONTROL, 32'h0);
        ticks(4);
        checkWord(32'(wakes), 32'h2);
        rdChk(IDX_INT_FLAG, 32'h1);
        endTest("wrap");
        // Each prescale code: 2r-1 rises give exactly one count
        wr(IDX_RTC_PERIOD, 32'hffff);
        foreach (ratio[i]) begin
            wr(IDX_RTC_CONTROL, 32'h8002 | (32'(i) << 4));
            wr(IDX_RTC_COUNT, 32'h0);
            ticks(2 * ratio[i] - 1);
            rdChk(IDX_RTC_COUNT, 32'h1);
        end
        endTest("prescale");
        results();
    end
endmodule
